// File: hw/lpp_pin_map.sv
// Interface-type pin mapping: picks each pin's role at its default polarity.
// Assumes role inputs are active-high assert requests on the same clock.
`timescale 1ns/1ps
`include "lpp_defs.svh"

module lpp_pin_map
   import lpp_pkg::*;
(
   input  wire lpp_mode_t mode_i,
   input  wire logic      role_enable_i,
   input  wire logic      role_read_strobe_i,
   input  wire logic      role_write_strobe_i,
   input  wire logic      role_direction_read_i,
   input  wire logic      role_address_latch_i,
   input  wire logic      role_select_zero_i,
   input  wire logic      role_select_one_i,
   output logic           pclk_lvl_o,
   output logic           hsync_lvl_o,
   output logic           vsync_lvl_o,
   output logic           bias_lvl_o,
   output logic           mclk_lvl_o
);

   always_comb begin
      pclk_lvl_o  = 1'b0;
      hsync_lvl_o = 1'b0;
      vsync_lvl_o = 1'b1;
      bias_lvl_o  = 1'b1;
      mclk_lvl_o  = 1'b1;
      case (mode_i)
         `LPP_MODE_MOTO: begin
            pclk_lvl_o  = role_enable_i;          // R2 R5
            hsync_lvl_o = role_direction_read_i;  // R5
            vsync_lvl_o = ~role_address_latch_i;  // R4 R5
            bias_lvl_o  = ~role_select_zero_i;    // R5
            mclk_lvl_o  = ~role_select_one_i;     // R5
         end
         `LPP_MODE_INTEL: begin
            pclk_lvl_o  = ~role_read_strobe_i;    // R2 R6
            hsync_lvl_o = ~role_write_strobe_i;   // R6
            vsync_lvl_o = ~role_address_latch_i;  // R4 R6
            bias_lvl_o  = ~role_select_zero_i;    // R6
            mclk_lvl_o  = ~role_select_one_i;     // R6
         end
         `LPP_MODE_INTEL_E: begin
            pclk_lvl_o  = 1'b0;                   // R7
            hsync_lvl_o = role_direction_read_i;  // R7
            vsync_lvl_o = ~role_address_latch_i;  // R4 R7
            bias_lvl_o  = role_select_zero_i;     // R7
            mclk_lvl_o  = role_select_one_i;      // R7
         end
         default: begin
            pclk_lvl_o  = 1'b0;
         end
      endcase
   end

endmodule : lpp_pin_map

// File: hw/lpp_top.sv
// Panel parallel port: control register, pin mapping and polarity stage.
// Assumes an Avalon-MM master on clk_i and role requests from a same-clock sequencer.
//
// What this block does
// R1: Read-strobe polarity bit 4 inverts pixel pin
// R2: Default: read strobe low-active, enable high-active
// R3: Address-latch polarity bit 3 inverts latch pin
// R4: Default address latch is active low
// R5: Mode 001b maps enable, direction, latch, selects
// R6: Mode 011b maps read, write, latch, selects
// R7: Mode 100b: pixel pin unused, strobes on selects
// R8: Software configures before streaming, stops before changes; ctrl_r still takes writes while streaming is on
// R9: Polarity inversion is last stage after mapping
`timescale 1ns/1ps
`include "lpp_defs.svh"

module lpp_top
   import lpp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        role_enable_i,
   input  wire logic        role_read_strobe_i,
   input  wire logic        role_write_strobe_i,
   input  wire logic        role_direction_read_i,
   input  wire logic        role_address_latch_i,
   input  wire logic        role_select_zero_i,
   input  wire logic        role_select_one_i,
   output logic             pixel_clock_pin_o,
   output logic             pixel_clock_pin_oe_o,
   output logic             horizontal_sync_pin_o,
   output logic             vertical_sync_pin_o,
   output logic             bias_or_select_pin_o,
   output logic             memory_clock_pin_o,
   output logic             panel_pins_oe_o,
   output logic             panel_stream_enable_o
);

   // ****************************************
   // Bus slave
   // ****************************************
   logic [`LPP_CTRL_MSB:0] ctrl_r;
   logic [31:0]            avs_readdata_r;
   logic                   ack_r;
   logic                   req;
   logic                   wr_take;
   logic [31:0]            ctrl_word;
   logic [31:0]            stat_word;
   logic [31:0]            ctrl_merge;

   // One wait state: readdata loads at the same edge that drops waitrequest
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_r;
   assign wr_take           = avs_write_i & ack_r;
   assign avs_readdata_o    = avs_readdata_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   assign ctrl_word = {{(31 - `LPP_CTRL_MSB){1'b0}}, ctrl_r};

   always_comb begin
      ctrl_merge = ctrl_word;
      for (int b = 0; b < 4; b++) begin
         if (avs_byteenable_i[b]) begin
            ctrl_merge[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
         end
      end
   end

   // Streaming enable shares this register; software keeps it off while reprogramming
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `LPP_CTRL_RESET;
      end else if (wr_take && avs_address_i == `LPP_CTRL_OFS) begin
         ctrl_r <= ctrl_merge[`LPP_CTRL_MSB:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_r <= 32'h0000_0000;
      end else if (avs_read_i && !ack_r) begin
         case (avs_address_i)
            `LPP_CTRL_OFS: avs_readdata_r <= ctrl_word;
            `LPP_STAT_OFS: avs_readdata_r <= stat_word;
            default:       avs_readdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Control fields
   // ****************************************
   lpp_mode_t mode;
   logic      rs_pol;
   logic      ale_pol;

   assign mode                  = ctrl_r[`LPP_MODE_MSB:`LPP_MODE_LSB];
   assign rs_pol                = ctrl_r[`LPP_RS_POL_BIT];
   assign ale_pol               = ctrl_r[`LPP_ALE_POL_BIT];
   assign panel_stream_enable_o = ctrl_r[`LPP_STREAM_BIT];

   // ****************************************
   // Pin mapping
   // ****************************************
   logic pclk_lvl;
   logic hsync_lvl;
   logic vsync_lvl;
   logic bias_lvl;
   logic mclk_lvl;

   lpp_pin_map u_map (
      .mode_i                (mode),
      .role_enable_i         (role_enable_i),
      .role_read_strobe_i    (role_read_strobe_i),
      .role_write_strobe_i   (role_write_strobe_i),
      .role_direction_read_i (role_direction_read_i),
      .role_address_latch_i  (role_address_latch_i),
      .role_select_zero_i    (role_select_zero_i),
      .role_select_one_i     (role_select_one_i),
      .pclk_lvl_o            (pclk_lvl),
      .hsync_lvl_o           (hsync_lvl),
      .vsync_lvl_o           (vsync_lvl),
      .bias_lvl_o            (bias_lvl),
      .mclk_lvl_o            (mclk_lvl)
   );

   // ****************************************
   // Polarity stage and pin registers
   // ****************************************
   // Inversion after mapping, so one bit serves both enable and read-strobe roles
   logic pclk_nxt;
   logic vsync_nxt;

   assign pclk_nxt  = lpp_pclk_used(mode) ? (pclk_lvl ^ rs_pol) : 1'b0;  // R1 R9
   assign vsync_nxt = lpp_mode_valid(mode) ? (vsync_lvl ^ ale_pol) : 1'b1; // R3 R9

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pixel_clock_pin_o     <= 1'b0;
         horizontal_sync_pin_o <= 1'b0;
         vertical_sync_pin_o   <= 1'b1;
         bias_or_select_pin_o  <= 1'b1;
         memory_clock_pin_o    <= 1'b1;
      end else begin
         pixel_clock_pin_o     <= pclk_nxt;  // R1
         horizontal_sync_pin_o <= hsync_lvl;
         vertical_sync_pin_o   <= vsync_nxt; // R3
         bias_or_select_pin_o  <= bias_lvl;
         memory_clock_pin_o    <= mclk_lvl;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pixel_clock_pin_oe_o <= 1'b0;
         panel_pins_oe_o      <= 1'b0;
      end else begin
         pixel_clock_pin_oe_o <= lpp_pclk_used(mode); // R7
         panel_pins_oe_o      <= lpp_mode_valid(mode);
      end
   end

   assign stat_word = {25'h0000000, panel_pins_oe_o, pixel_clock_pin_oe_o,
                       memory_clock_pin_o, bias_or_select_pin_o, vertical_sync_pin_o,
                       horizontal_sync_pin_o, pixel_clock_pin_o};

   // ****************************************
   // Assertions
   // ****************************************
   a_rs_invert: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
      (mode == `LPP_MODE_INTEL) |=> (pixel_clock_pin_o == ($past(rs_pol) ^ ~$past(role_read_strobe_i))))
      else $error("read strobe pin polarity wrong");

   a_en_default: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
      (mode == `LPP_MODE_MOTO && !rs_pol && role_enable_i) |=> pixel_clock_pin_o)
      else $error("enable not high by default");

   a_ale_invert: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
      (lpp_mode_valid(mode) && ale_pol) |=> (vertical_sync_pin_o == $past(role_address_latch_i)))
      else $error("inverted latch pin wrong");

   a_ale_default: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
      (lpp_mode_valid(mode) && !ale_pol && role_address_latch_i) |=> !vertical_sync_pin_o)
      else $error("latch not active low");

   a_moto_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
      (mode == `LPP_MODE_MOTO) |=> (horizontal_sync_pin_o == $past(role_direction_read_i)
         && bias_or_select_pin_o == !$past(role_select_zero_i)
         && memory_clock_pin_o == !$past(role_select_one_i) && pixel_clock_pin_oe_o))
      else $error("mode 001 map wrong");

   a_intel_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
      (mode == `LPP_MODE_INTEL) |=> (horizontal_sync_pin_o == !$past(role_write_strobe_i)
         && bias_or_select_pin_o == !$past(role_select_zero_i)
         && memory_clock_pin_o == !$past(role_select_one_i)))
      else $error("mode 011 map wrong");

   a_strobe_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
      (mode == `LPP_MODE_INTEL_E) |=> (!pixel_clock_pin_oe_o && !pixel_clock_pin_o
         && bias_or_select_pin_o == $past(role_select_zero_i)
         && memory_clock_pin_o == $past(role_select_one_i)))
      else $error("mode 100 map wrong");

   a_pol_last: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
      (mode == `LPP_MODE_MOTO && $stable(role_enable_i) && $rose(rs_pol)) |=> $changed(pixel_clock_pin_o))
      else $error("polarity flip did not toggle pin");

endmodule : lpp_top

// File: shared/lpp_defs.svh
// Named offsets, field positions, reset values and mode codes of the panel port.
// Assumes inclusion by bare name; definitions only.
`ifndef LPP_DEFS_SVH
`define LPP_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define LPP_CTRL_OFS       4'h0
`define LPP_STAT_OFS       4'h4

// ****************************************
// Control field layout
// ****************************************
`define LPP_MODE_MSB       2
`define LPP_MODE_LSB       0
`define LPP_ALE_POL_BIT    3
`define LPP_RS_POL_BIT     4
`define LPP_STREAM_BIT     8
`define LPP_CTRL_MSB       10
`define LPP_CTRL_RESET     11'h000

// ****************************************
// Interface type codes
// ****************************************
`define LPP_MODE_MOTO      3'h1
`define LPP_MODE_INTEL     3'h3
`define LPP_MODE_INTEL_E   3'h4

// ****************************************
// Status field layout
// ****************************************
`define LPP_STAT_PINS_MSB  4
`define LPP_STAT_PCLK_OE   5
`define LPP_STAT_PINS_OE   6

`endif

// File: shared/lpp_pkg.sv
// Types and shared decoding of the panel parallel port.
// Assumes lpp_defs.svh is on the include path.
`include "lpp_defs.svh"

package lpp_pkg;

   typedef logic [2:0] lpp_mode_t;

   // Modes in which the pins carry a panel bus at all
   function automatic logic lpp_mode_valid(input lpp_mode_t mode);
      return (mode == `LPP_MODE_MOTO) || (mode == `LPP_MODE_INTEL) || (mode == `LPP_MODE_INTEL_E);
   endfunction : lpp_mode_valid

   // Pixel clock pin carries enable or read strobe
   function automatic logic lpp_pclk_used(input lpp_mode_t mode);
      return (mode == `LPP_MODE_MOTO) || (mode == `LPP_MODE_INTEL);
   endfunction : lpp_pclk_used

endpackage : lpp_pkg

// File: tb/lcd_parallel_polarity_pinmap_test.sv
// Self-checking bench of the panel port: register bus, pin mapping and polarity stage.
// Assumes lpp_pkg, lpp_defs.svh, the design and the panel model are compiled before it.
`timescale 1ns/1ps
`include "lpp_defs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module lcd_parallel_polarity_pinmap_test
   import lpp_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [3:0]  be = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wreq;
   logic [6:0]  roles = 7'h00;
   wire  [6:0]  pins;
   logic        stream;
   logic        ale_strap = 1'b0;
   logic        latch_seen;
   int          miscompares = 0;
   int          n_tests = 0;

   always #2.5 clk_i = ~clk_i;

   lpp_top uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_byteenable_i(be), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .role_enable_i(roles[6]), .role_read_strobe_i(roles[5]), .role_write_strobe_i(roles[4]),
      .role_direction_read_i(roles[3]), .role_address_latch_i(roles[2]), .role_select_zero_i(roles[1]),
      .role_select_one_i(roles[0]), .pixel_clock_pin_o(pins[6]), .pixel_clock_pin_oe_o(pins[5]),
      .horizontal_sync_pin_o(pins[4]), .vertical_sync_pin_o(pins[3]), .bias_or_select_pin_o(pins[2]),
      .memory_clock_pin_o(pins[1]), .panel_pins_oe_o(pins[0]), .panel_stream_enable_o(stream)
   );

   lpp_panel_model panel (
      .vsync_i(pins[3]), .pins_oe_i(pins[0]), .latch_pol_i(ale_strap), .latch_seen_o(latch_seen)
   );

   // ****************************************
   // Expectations and drivers
   // ****************************************
   // p = {read strobe polarity, address latch polarity}; result in the order of pins
   function automatic logic [6:0] exp_pins(input lpp_mode_t m, input logic [1:0] p, input logic [6:0] r);
      logic en, rs, ws, dr, al, s0, s1;
      logic [6:0] e;
      {en, rs, ws, dr, al, s0, s1} = r;
      e = 7'h0E;
      if (m == `LPP_MODE_MOTO || m == `LPP_MODE_INTEL || m == `LPP_MODE_INTEL_E)
         e = {1'b0, 1'b0, dr, ~al ^ p[0], s0, s1, 1'b1};
      if (m == `LPP_MODE_MOTO)
         e = {en ^ p[1], 1'b1, dr, e[3], ~s0, ~s1, 1'b1};
      if (m == `LPP_MODE_INTEL)
         e = {~rs ^ p[1], 1'b1, ~ws, e[3], ~s0, ~s1, 1'b1};
      return e;
   endfunction : exp_pins

   // Waitrequest and read data are taken at the rising edge; only the watchdog ends a hung wait
   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      addr <= a;
      be <= b;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk_i);
      end while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic step(input lpp_mode_t m, input logic [1:0] p);
      logic [6:0] r;
      logic [6:0] e;
      r = 7'($urandom);
      e = exp_pins(m, p, r);
      @(posedge clk_i);
      roles <= r;
      @(posedge clk_i);
      #1;
      `CHK("pins", e, pins)
      `CHK("latch", e[0] & r[2], latch_seen)
   endtask : step

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      logic [31:0] cfg;
      void'($urandom(49541));
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      `CHK("idle pins", 7'h0E, pins)
      bus(1'b0, `LPP_CTRL_OFS, 4'hF, 32'h0, q);
      `CHK("ctrl reset", 32'h0, q)
      bus(1'b1, `LPP_CTRL_OFS, 4'hF, 32'hFFFF_FFFF, q);
      bus(1'b0, `LPP_CTRL_OFS, 4'hF, 32'h0, q);
      `CHK("ctrl bits", 32'h0000_07FF, q)
      `CHK("stream on", 1'b1, stream)
      bus(1'b1, `LPP_CTRL_OFS, 4'h2, 32'h0, q);
      bus(1'b0, `LPP_CTRL_OFS, 4'hF, 32'h0, q);
      `CHK("byte lane", 32'h0000_00FF, q)
      bus(1'b1, `LPP_CTRL_OFS, 4'hF, 32'h0, q);
      bus(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF, q);
      bus(1'b0, 4'h8, 4'hF, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      bus(1'b1, `LPP_STAT_OFS, 4'hF, 32'hFFFF_FFFF, q);
      bus(1'b0, `LPP_STAT_OFS, 4'hF, 32'h0, q);
      `CHK("status idle", 32'h0000_001C, q)
      for (int m = 0; m < 8; m++) begin
         for (int p = 0; p < 4; p++) begin
            cfg = 32'(m) | (32'(p & 1) << `LPP_ALE_POL_BIT) | (32'(p >> 1) << `LPP_RS_POL_BIT);
            ale_strap <= p[0];
            // Configure with streaming off, then turn it on, then off again before the next change
            bus(1'b1, `LPP_CTRL_OFS, 4'hF, cfg, q);
            bus(1'b1, `LPP_CTRL_OFS, 4'hF, cfg | 32'h0000_0100, q);
            // The write lands at the edge that ends the bus call; look once it has settled
            #1;
            `CHK("stream", 1'b1, stream)
            repeat (6) step(lpp_mode_t'(m), 2'(p));
            bus(1'b1, `LPP_CTRL_OFS, 4'hF, cfg, q);
            bus(1'b0, `LPP_CTRL_OFS, 4'hF, 32'h0, q);
            `CHK("ctrl", cfg, q)
            `CHK("stream off", 1'b0, stream)
         end
      end
      report_and_stop();
   end

   initial begin
      #(5 * 40000);
      miscompares++;
      report_and_stop();
   end
endmodule : lcd_parallel_polarity_pinmap_test

// File: tb/lpp_panel_model.sv
// Panel-side model: a character panel that watches the latch line of the port.
// Assumes its latch polarity strap follows the port's address-latch polarity bit.
`timescale 1ns/1ps

module lpp_panel_model (
   input  wire logic vsync_i,
   input  wire logic pins_oe_i,
   input  wire logic latch_pol_i,
   output logic      latch_seen_o
);
   // Undriven pins latch nothing, so a floating line never counts as a latch
   assign latch_seen_o = pins_oe_i & (vsync_i == latch_pol_i);
endmodule : lpp_panel_model
